// [nfc_ctrl_regs.sv]
/*
  flash controller configuration, parameter and interrupt-enable registers,
  read wait-state sequencer, sleep power reduction and auto page write start.
  assumes a single-cycle peripheral register port with byte enables, and that
  the command, status and array blocks supply fault pulses and readiness.
*/
`include "nfc_cfg.svh"

module nfc_ctrl_regs #(
  parameter logic [2:0] PAGE_SIZE_CODE = 3'h3,
  parameter logic [15:0] PAGE_COUNT = 16'h0100
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic reg_sel_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [3:0] reg_be_in,
  input wire logic [31:0] reg_wdata_in,
  output logic [31:0] reg_rdata_out,
  input wire logic fetch_req_in,
  input wire logic cache_hit_in,
  output logic fetch_done_out,
  output logic cache_off_out,
  output logic [1:0] cache_read_policy_out,
  output logic [3:0] read_wait_count_out,
  input wire logic sleep_in,
  input wire logic prm_set_cmd_in,
  input wire logic prm_clr_cmd_in,
  output logic low_power_out,
  input wire logic buf_load_in,
  input wire logic buf_last_word_in,
  output logic auto_page_write_out,
  output logic manual_page_write_out,
  input wire logic flash_ready_in,
  input wire logic controller_fault_in,
  input wire logic lock_violation_in,
  input wire logic programming_fault_in,
  output logic [1:0] irq_flags_out,
  output logic irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  // byte-lane write merge
  function automatic logic [31:0] nfc_merge(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0] be,
    input logic [31:0] mask
  );
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res & mask;
  endfunction

  // write-one lane mask
  function automatic logic [1:0] nfc_w1(
    input logic [31:0] wdata,
    input logic [3:0] be
  );
    return be[0] ? wdata[1:0] : 2'h0;
  endfunction

  // wait states for one read
  function automatic logic [4:0] nfc_waits(
    input logic [1:0] policy,
    input logic hit,
    input logic [3:0] wait_set
  );
    logic [4:0] n;
    n = {1'b0, wait_set};
    if (hit) begin
      if (policy == `NFC_POLICY_DETERMINISTIC) begin
        n = {1'b0, wait_set};
      end else begin
        n = 5'h00;
      end
    end else if (policy == `NFC_POLICY_LOW_POWER) begin
      n = 5'({1'b0, wait_set} + `NFC_LOW_POWER_MISS_WAITS);
    end
    return n;
  endfunction

  // pack control register image
  function automatic logic [31:0] nfc_ctrl_word(input nfc_pkg::nfc_ctrl_t c);
    logic [31:0] w;
    w = 32'h00000000;
    w[`NFC_POS_CACHE_OFF] = c.cache_off;
    w[`NFC_POS_READ_POLICY +: 2] = c.cache_read_policy;
    w[`NFC_POS_SLEEP_POLICY +: 2] = c.sleep_power_policy;
    w[`NFC_POS_MANUAL_WRITE] = c.manual_page_write;
    w[`NFC_POS_WAIT_COUNT +: 4] = c.read_wait_count;
    return w;
  endfunction

  // unpack control register image
  function automatic nfc_pkg::nfc_ctrl_t nfc_ctrl_fields(input logic [31:0] w);
    nfc_pkg::nfc_ctrl_t c;
    c.cache_off = w[`NFC_POS_CACHE_OFF];
    c.cache_read_policy = w[`NFC_POS_READ_POLICY +: 2];
    c.sleep_power_policy = w[`NFC_POS_SLEEP_POLICY +: 2];
    c.manual_page_write = w[`NFC_POS_MANUAL_WRITE];
    c.read_wait_count = w[`NFC_POS_WAIT_COUNT +: 4];
    return c;
  endfunction

  // sleep policies that power down
  function automatic logic nfc_sleep_auto(input logic [1:0] policy);
    return policy == `NFC_SLEEP_WAKE_ACCESS || policy == `NFC_SLEEP_WAKE_SYSTEM;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  nfc_pkg::nfc_state_t state_q;
  nfc_pkg::nfc_state_t state_d;
  nfc_pkg::nfc_state_t state_rst;

  logic wr_strobe;
  logic rd_strobe;
  logic [31:0] ctrl_img;
  logic [31:0] ctrl_new;
  logic [1:0] w1_bits;
  logic hit_eff;
  logic [4:0] req_waits;
  logic fault_evt;
  logic [1:0] flags_now;
  logic wr_ctrl;
  logic wr_irq_clr;
  logic wr_irq_set;
  logic wr_flags;

  always_comb begin
    state_rst = '0;
    state_rst.ctrl = nfc_ctrl_fields(`NFC_RST_CTRL_TWO);
    state_rst.irq_en = `NFC_RST_IRQ_EN;
    state_rst.fetch_st = nfc_pkg::NFC_ST_IDLE;
  end

  assign wr_strobe = reg_sel_in & reg_wr_in;
  assign rd_strobe = reg_sel_in & ~reg_wr_in;
  assign wr_ctrl = wr_strobe && reg_addr_in == `NFC_OFF_CTRL_TWO;
  assign wr_irq_clr = wr_strobe && reg_addr_in == `NFC_OFF_IRQ_CLR;
  assign wr_irq_set = wr_strobe && reg_addr_in == `NFC_OFF_IRQ_SET;
  assign wr_flags = wr_strobe && reg_addr_in == `NFC_OFF_IRQ_FLAGS;
  assign ctrl_img = nfc_ctrl_word(state_q.ctrl);
  assign w1_bits = nfc_w1(reg_wdata_in, reg_be_in);
  assign hit_eff = cache_hit_in & ~state_q.ctrl.cache_off;
  assign req_waits = nfc_waits(state_q.ctrl.cache_read_policy, hit_eff,
                               state_q.ctrl.read_wait_count);
  assign fault_evt = controller_fault_in | lock_violation_in | programming_fault_in;
  assign flags_now = {state_q.err_flag, flash_ready_in};

  assign ctrl_new = nfc_merge(ctrl_img, reg_wdata_in, reg_be_in, `NFC_CTRL_TWO_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    state_d = state_q;
    state_d.auto_write = 1'b0;
    fetch_done_out = 1'b0;

    // control register write
    if (wr_ctrl) begin
      state_d.ctrl = nfc_ctrl_fields(ctrl_new);
    end

    if (wr_irq_clr) begin
      state_d.irq_en = state_q.irq_en & ~w1_bits;
    end

    if (wr_irq_set) begin
      state_d.irq_en = state_q.irq_en | w1_bits;
    end

    if (wr_flags && w1_bits[`NFC_POS_ERROR]) begin
      state_d.err_flag = 1'b0;
    end
    if (fault_evt) begin
      state_d.err_flag = 1'b1;
    end

    // read wait sequencer
    case (state_q.fetch_st)
      nfc_pkg::NFC_ST_IDLE: begin
        if (fetch_req_in) begin
          if (req_waits == 5'h00) begin
            fetch_done_out = 1'b1;
          end else begin
            state_d.wait_cnt = 5'(req_waits - 5'h01);
            state_d.fetch_st = nfc_pkg::NFC_ST_WAIT;
          end
        end
      end
      nfc_pkg::NFC_ST_WAIT: begin
        if (state_q.wait_cnt == 5'h00) begin
          fetch_done_out = 1'b1;
          state_d.fetch_st = nfc_pkg::NFC_ST_IDLE;
        end else begin
          state_d.wait_cnt = 5'(state_q.wait_cnt - 5'h01);
        end
      end
      default: begin
        state_d.fetch_st = nfc_pkg::NFC_ST_IDLE;
        state_d.wait_cnt = 5'h00;
      end
    endcase

    // sleep power reduction
    state_d.sleep_seen = sleep_in;
    if (prm_clr_cmd_in) begin
      state_d.prm = 1'b0;
    end
    if (fetch_req_in && state_q.ctrl.sleep_power_policy == `NFC_SLEEP_WAKE_ACCESS) begin
      state_d.prm = 1'b0;
    end
    if (!sleep_in && state_q.sleep_seen &&
        state_q.ctrl.sleep_power_policy == `NFC_SLEEP_WAKE_SYSTEM) begin
      state_d.prm = 1'b0;
    end
    if (sleep_in && !state_q.sleep_seen &&
        nfc_sleep_auto(state_q.ctrl.sleep_power_policy)) begin
      state_d.prm = 1'b1;
    end
    if (prm_set_cmd_in) begin
      state_d.prm = 1'b1;
    end

    if (buf_load_in && buf_last_word_in && !state_q.ctrl.manual_page_write) begin
      state_d.auto_write = 1'b1;
    end

    state_d.irq = |({state_d.err_flag, flash_ready_in} & state_d.irq_en);

    // register read data
    if (rd_strobe) begin
      case (reg_addr_in)
        `NFC_OFF_CTRL_TWO: begin
          state_d.rdata = ctrl_img;
        end
        `NFC_OFF_PARAMS: begin
          state_d.rdata = {13'h0000, PAGE_SIZE_CODE, PAGE_COUNT};
        end
        `NFC_OFF_IRQ_CLR, `NFC_OFF_IRQ_SET: begin
          state_d.rdata = {30'h00000000, state_q.irq_en};
        end
        `NFC_OFF_IRQ_FLAGS: begin
          state_d.rdata = {30'h00000000, flags_now};
        end
        default: begin
          state_d.rdata = 32'h00000000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      state_q <= state_rst;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata_out = state_q.rdata;
  assign cache_off_out = state_q.ctrl.cache_off;
  assign cache_read_policy_out = state_q.ctrl.cache_read_policy;
  assign read_wait_count_out = state_q.ctrl.read_wait_count;
  assign low_power_out = state_q.prm;
  assign auto_page_write_out = state_q.auto_write;
  assign manual_page_write_out = state_q.ctrl.manual_page_write;
  assign irq_flags_out = {state_q.err_flag, flash_ready_in};
  assign irq_out = state_q.irq;

endmodule

// [nfc_cfg.svh]
/*
  offsets, field positions, reset values and codes of the flash controller
  configuration and interrupt-enable registers.
  assumes byte offsets on the peripheral register port, one word per register.
*/
// Overview of operation
// - cache_off bit 18 disables read cache
// - fast_miss_policy adds no miss wait states
// - low-power policy adds one wait per miss
// - deterministic policy: hit and miss equal; 0x3 reserved
// - sleep policy 0x0/0x1 enters low power; 0x3 off
// - wake_on_first_access leaves low power on access
// - wake_with_system leaves low power when sleep ends
// - auto page write on last buffer word
// - manual_page_write blocks auto write; software commands
// - read_wait_count bits 4:1 sets read waits
// - read_wait_count resets to zero
// - reserved bits read zero, writes ignored
// - page_size_code bits 18:16 read only
// - page_count bits 15:0 read only
// - irq_enable_clear write one clears enable
// - irq_enable_set write one sets enable
// - both enable registers share state, reset zero
// - error flag sticky on faults, write-one clears
// - ready flag follows controller readiness
`ifndef NFC_CFG_SVH
`define NFC_CFG_SVH
`define NFC_OFF_CTRL_TWO 8'h04
`define NFC_OFF_PARAMS 8'h08
`define NFC_OFF_IRQ_CLR 8'h0c
`define NFC_OFF_IRQ_SET 8'h10
`define NFC_OFF_IRQ_FLAGS 8'h14
`define NFC_POS_CACHE_OFF 18
`define NFC_POS_READ_POLICY 16
`define NFC_POS_SLEEP_POLICY 8
`define NFC_POS_MANUAL_WRITE 7
`define NFC_POS_WAIT_COUNT 1
`define NFC_POS_PAGE_SIZE 16
`define NFC_POS_ERROR 1
`define NFC_POS_READY 0
`define NFC_CTRL_TWO_MASK 32'h0007039e
`define NFC_IRQ_MASK 32'h00000003
`define NFC_RST_CTRL_TWO 32'h00000000
`define NFC_RST_IRQ_EN 2'h0
`define NFC_POLICY_FAST 2'h0
`define NFC_POLICY_LOW_POWER 2'h1
`define NFC_POLICY_DETERMINISTIC 2'h2
`define NFC_SLEEP_WAKE_ACCESS 2'h0
`define NFC_SLEEP_WAKE_SYSTEM 2'h1
`define NFC_SLEEP_DISABLED 2'h3
`define NFC_LOW_POWER_MISS_WAITS 5'h01
`endif

// [nfc_pkg.sv]
/*
  types of the flash controller configuration block.
  assumes nfc_cfg.svh for every number except the fetch state codes.
*/
package nfc_pkg;

  typedef enum logic [1:0] {
    NFC_ST_IDLE = 2'b01,
    NFC_ST_WAIT = 2'b10
  } nfc_fetch_st_t;

  typedef struct packed {
    logic cache_off;
    logic [1:0] cache_read_policy;
    logic [1:0] sleep_power_policy;
    logic manual_page_write;
    logic [3:0] read_wait_count;
  } nfc_ctrl_t;

  typedef struct packed {
    nfc_ctrl_t ctrl;
    logic [1:0] irq_en;
    logic err_flag;
    logic prm;
    logic sleep_seen;
    nfc_fetch_st_t fetch_st;
    logic [4:0] wait_cnt;
    logic [31:0] rdata;
    logic irq;
    logic auto_write;
  } nfc_state_t;

endpackage

// [nfc_ctrl_regs_props.sv]
/*
  concurrent checks of the flash controller configuration block.
  assumes binding to nfc_ctrl_regs, one clock, synchronous active-low reset.
*/
module nfc_ctrl_regs_props #(
  parameter logic [2:0] PAGE_SIZE_CODE = 3'h3,
  parameter logic [15:0] PAGE_COUNT = 16'h0100
) (
  input logic clk_in,
  input logic rst_b_in,
  input logic reg_sel_in,
  input logic reg_wr_in,
  input logic [7:0] reg_addr_in,
  input logic [31:0] reg_rdata_out,
  input logic fetch_req_in,
  input logic cache_hit_in,
  input logic fetch_done_out,
  input logic cache_off_out,
  input logic [1:0] cache_read_policy_out,
  input logic [3:0] read_wait_count_out,
  input logic buf_load_in,
  input logic buf_last_word_in,
  input logic auto_page_write_out,
  input logic manual_page_write_out,
  input logic flash_ready_in,
  input logic controller_fault_in,
  input logic lock_violation_in,
  input logic programming_fault_in,
  input logic [1:0] irq_flags_out,
  input logic irq_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  ////////////////////////////////////////////////////////////////////////////
  sequence one_wait_s;
    !fetch_done_out ##1 fetch_done_out;
  endsequence
  sequence two_wait_s;
    !fetch_done_out [*2] ##1 fetch_done_out;
  endsequence
  sequence last_word_s;
    buf_load_in && buf_last_word_in;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  fast_miss_a: assert property (
    fetch_req_in && cache_read_policy_out == 2'h0 && read_wait_count_out == 4'h0
    |-> fetch_done_out) else $error("fetch late without waits");
  low_power_miss_a: assert property (
    fetch_req_in && !cache_hit_in && cache_read_policy_out == 2'h1 &&
    read_wait_count_out == 4'h0 |-> one_wait_s) else $error("miss wait wrong");
  det_hit_a: assert property (
    fetch_req_in && cache_hit_in && !cache_off_out && cache_read_policy_out == 2'h2 &&
    read_wait_count_out == 4'h2 |-> two_wait_s) else $error("hit time wrong");
  auto_write_a: assert property (
    last_word_s ##0 !manual_page_write_out |=> auto_page_write_out)
    else $error("no page write start");
  manual_write_a: assert property (
    last_word_s ##0 manual_page_write_out |=> !auto_page_write_out)
    else $error("page write in manual mode");
  error_flag_a: assert property (
    controller_fault_in || lock_violation_in || programming_fault_in |=> irq_flags_out[1])
    else $error("error flag not set");
  ready_flag_a: assert property (
    reg_sel_in && !reg_wr_in && reg_addr_in == 8'h14
    |=> reg_rdata_out[0] == $past(flash_ready_in)) else $error("ready flag wrong");
  irq_cause_a: assert property (
    $rose(irq_out) |-> irq_flags_out[1] || $past(irq_flags_out[0]))
    else $error("irq without flag");
  flash_parameters_read_a: assert property (
    reg_sel_in && !reg_wr_in && reg_addr_in == 8'h08
    |=> reg_rdata_out == {13'h0, PAGE_SIZE_CODE, PAGE_COUNT}) else $error("flash_parameters wrong");
endmodule
bind nfc_ctrl_regs nfc_ctrl_regs_props #(.PAGE_SIZE_CODE(PAGE_SIZE_CODE),
  .PAGE_COUNT(PAGE_COUNT)) u_props (.*);

// [test_nfc_ctrl_regs.sv]
/*
  self-checking bench of the flash controller configuration block.
  assumes default page parameters; the bench drives every input.
*/
module test_nfc_ctrl_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 0, rst_b_in = 0, reg_sel_in = 0, reg_wr_in = 0, fetch_req_in = 0;
  logic cache_hit_in = 0, sleep_in = 0, prm_set_cmd_in = 0, prm_clr_cmd_in = 0;
  logic buf_load_in = 0, buf_last_word_in = 0, flash_ready_in = 0;
  logic controller_fault_in = 0, lock_violation_in = 0, programming_fault_in = 0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [3:0] reg_be_in = 4'h0;
  logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out;
  logic fetch_done_out, cache_off_out, low_power_out, auto_page_write_out;
  logic manual_page_write_out, irq_out;
  logic [1:0] cache_read_policy_out, irq_flags_out;
  logic [3:0] read_wait_count_out;
  int num_errors = 0, n_tests = 0;
  nfc_ctrl_regs uut (.*);
  always #5 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    tick(1);
    reg_sel_in = 1;
    reg_wr_in = w;
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_be_in = 4'hf;
    tick(1);
    reg_sel_in = 0;
    reg_wr_in = 0;
  endtask
  task automatic fetch(input logic [1:0] p, input logic [3:0] w, input logic h,
    input logic o, input int n);
    int k;
    k = 0;
    acc(1, 8'h04, {13'h0, o, p, 11'h0, w, 1'b0});
    fetch_req_in = 1;
    cache_hit_in = h;
    #1;
    while (fetch_done_out !== 1'b1 && k < 20) begin
      tick(1);
      fetch_req_in = 0;
      #1;
      k++;
    end
    chk(k, n);
    tick(1);
    fetch_req_in = 0;
  endtask
  task automatic slp(input logic [1:0] p, input logic e1, input logic e2);
    acc(1, 8'h04, {22'h0, p, 8'h0});
    sleep_in = 1;
    tick(3);
    chk(low_power_out, e1);
    sleep_in = 0;
    tick(3);
    chk(low_power_out, e2);
  endtask
  task automatic ld(input logic e);
    buf_load_in = 1;
    buf_last_word_in = 1;
    tick(1);
    buf_load_in = 0;
    chk(auto_page_write_out, e);
    tick(1);
    chk(auto_page_write_out, 0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    acc(0, 8'h04, 32'h0);
    chk(reg_rdata_out, 32'h0);
    acc(0, 8'h10, 32'h0);
    chk(reg_rdata_out, 32'h0);
    acc(1, 8'h04, 32'hffffffff);
    acc(0, 8'h04, 32'h0);
    chk(reg_rdata_out, 32'h0007039e);
    chk({cache_off_out, read_wait_count_out}, 5'h1f);
    chk({cache_read_policy_out, manual_page_write_out}, 3'h7);
    acc(1, 8'h08, 32'hffffffff);
    acc(0, 8'h08, 32'h0);
    chk(reg_rdata_out, 32'h00030100);
    acc(0, 8'h40, 32'h0);
    chk(reg_rdata_out, 32'h0);
    $display("regs test done");
  endtask
  task automatic t_fetch;
    fetch(2'h0, 4'h0, 0, 0, 0);
    fetch(2'h0, 4'h2, 0, 0, 2);
    fetch(2'h0, 4'hf, 0, 0, 15);
    fetch(2'h1, 4'h0, 0, 0, 1);
    fetch(2'h1, 4'h3, 1, 0, 0);
    fetch(2'h2, 4'h2, 1, 0, 2);
    fetch(2'h2, 4'h2, 0, 0, 2);
    fetch(2'h0, 4'h1, 1, 1, 1);
    fetch(2'h3, 4'h0, 0, 0, 0);
    $display("fetch test done");
  endtask
  task automatic t_power;
    slp(2'h0, 1, 1);
    fetch(2'h0, 4'h0, 0, 0, 0);
    chk(low_power_out, 0);
    slp(2'h1, 1, 0);
    slp(2'h3, 0, 0);
    prm_set_cmd_in = 1;
    tick(1);
    prm_set_cmd_in = 0;
    chk(low_power_out, 1);
    prm_clr_cmd_in = 1;
    tick(1);
    prm_clr_cmd_in = 0;
    tick(1);
    chk(low_power_out, 0);
    $display("power test done");
  endtask
  task automatic t_write;
    acc(1, 8'h04, 32'h0);
    ld(1);
    acc(1, 8'h04, 32'h80);
    ld(0);
    $display("write test done");
  endtask
  task automatic t_irq;
    flash_ready_in = 1;
    acc(1, 8'h10, 32'h1);
    acc(0, 8'h0c, 32'h0);
    chk(reg_rdata_out, 32'h1);
    chk(irq_out, 1);
    acc(1, 8'h0c, 32'h0);
    acc(0, 8'h10, 32'h0);
    chk(reg_rdata_out, 32'h1);
    acc(1, 8'h0c, 32'h1);
    acc(0, 8'h10, 32'h0);
    chk({reg_rdata_out[1:0], irq_out}, 3'h0);
    acc(1, 8'h10, 32'h2);
    lock_violation_in = 1;
    tick(1);
    lock_violation_in = 0;
    tick(1);
    chk({irq_flags_out, irq_out}, 3'h7);
    acc(0, 8'h14, 32'h0);
    chk(reg_rdata_out, 32'h3);
    acc(1, 8'h14, 32'h2);
    flash_ready_in = 0;
    tick(1);
    chk({irq_flags_out, irq_out}, 3'h0);
    programming_fault_in = 1;
    tick(1);
    programming_fault_in = 0;
    chk(irq_flags_out, 2'h2);
    acc(1, 8'h14, 32'h2);
    chk(irq_flags_out, 2'h0);
    tick(1);
    reg_sel_in = 1;
    reg_wr_in = 1;
    controller_fault_in = 1;
    tick(1);
    reg_sel_in = 0;
    reg_wr_in = 0;
    controller_fault_in = 0;
    chk(irq_flags_out, 2'h2);
    $display("irq test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    tick(5);
    rst_b_in = 1;
    t_regs;
    t_fetch;
    t_power;
    t_write;
    t_irq;
    results;
  end
  initial begin
    #50000;
    num_errors++;
    results;
  end
endmodule
